// ===== include/tlip_pkg.sv
package tlip_pkg;

	// ********************************************************************
	// Sizes.
	// ********************************************************************
	localparam int SOURCES = 12;
	localparam int FLAGS   = 17;

	// ********************************************************************
	// Register byte offsets on the Wishbone slave.
	// ********************************************************************
	localparam logic [7:0] OFS_ENABLE  = 8'ha8;
	localparam logic [7:0] OFS_EXT_EN  = 8'hac;
	localparam logic [7:0] OFS_PRIO    = 8'hb0;
	localparam logic [7:0] OFS_PEND    = 8'hb4;
	localparam logic [7:0] OFS_IRQMASK = 8'hb8;
	localparam logic [7:0] OFS_STATUS  = 8'hbc;

	// ********************************************************************
	// Field positions and reset values.
	// ********************************************************************
	localparam int         BIT_GLOBAL_EN = 7;
	localparam int         SRC_EN_BITS   = 6;
	localparam logic [7:0] EN_RST        = 8'h00;
	localparam logic [5:0] EXT_EN_RST    = 6'h00;
	localparam logic [11:0] PRIO_RST     = 12'h000;

	// ********************************************************************
	// Vectors and pending flag layout.
	// ********************************************************************
	localparam logic [15:0] VEC_RESET  = 16'h0000;
	localparam logic [15:0] VEC_FIRST  = 16'h0003;
	localparam logic [11:0] HW_CLR_SRC = 12'h00f;
	localparam logic [11:0][16:0] SRC_FLAGS = {
		17'h10000, 17'h08000, 17'h07800, 17'h00400,
		17'h00200, 17'h00100, 17'h000c0, 17'h00030,
		17'h00008, 17'h00004, 17'h00002, 17'h00001};

	// ********************************************************************
	// Response budget in system clocks, the core providing all but detection.
	// ********************************************************************
	localparam int DETECT_CYC = 1;
	localparam int CALL_CYC   = 4;
	localparam int RET_CYC    = 5;
	localparam int DIV_CYC    = 8;
	localparam int BEST_CYC   = DETECT_CYC + CALL_CYC;
	localparam int WORST_CYC  = DETECT_CYC + RET_CYC + DIV_CYC + CALL_CYC;

	// ********************************************************************
	// Whole state of the top module.
	// ********************************************************************
	typedef struct packed {
		logic [7:0]  en;
		logic [5:0]  ext_en;
		logic [11:0] prio;
		logic [16:0] pend;
		logic [16:0] mask;
		logic        act_hi;
		logic        act_lo;
		logic        hold;
		logic        req;
		logic [15:0] vector;
		logic [3:0]  idx;
		logic        lvl;
		logic        irq;
		logic        wb_ack;
		logic [31:0] wb_dat;
	} tlip_state_t;

	localparam tlip_state_t STATE_RST = '{en: EN_RST, ext_en: EXT_EN_RST, prio: PRIO_RST,
		vector: VEC_RESET, default: '0};

endpackage

// ===== include/tlip_pick_if.sv
`timescale 1ns/1ps
interface tlip_pick_if #(
	parameter int N = 12
);
	logic [N-1:0]         req;
	logic [N-1:0]         hi;
	logic                 valid;
	logic                 lvl;
	logic [$clog2(N)-1:0] idx;

	modport user   (output req, output hi, input valid, input lvl, input idx);
	modport picker (input req, input hi, output valid, output lvl, output idx);
endinterface

// ===== logic/tlip_pick.sv
`timescale 1ns/1ps
module tlip_pick #(
	parameter int N = 12
) (
	// Requests and their levels.
	tlip_pick_if.picker pk
);

	logic [N-1:0] hi_req;
	logic [N-1:0] pool;

	// High level wins; the lowest order number wins within a level.
	always_comb begin
		hi_req   = pk.req & pk.hi;
		pool     = (|hi_req) ? hi_req : pk.req;
		pk.valid = |pk.req;
		pk.lvl   = |hi_req;
		pk.idx   = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (pool[i]) begin
				pk.idx = ($clog2(N))'(i);
			end
		end
	end

endmodule

// ===== logic/tlip_top.sv
`timescale 1ns/1ps
module tlip_top (
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// Wishbone slave.
	input  wire logic        wb_cyc,
	input  wire logic        wb_stb,
	input  wire logic        wb_we,
	input  wire logic [7:0]  wb_adr,
	input  wire logic [3:0]  wb_sel,
	input  wire logic [31:0] wb_dat_w,
	output logic             wb_ack,
	output logic [31:0]      wb_dat_r,
	// Pending flag set events from peripherals and pins.
	input  wire logic [16:0] flag_set,
	// Processor core.
	input  wire logic        call_ack,
	input  wire logic        ret_done,
	input  wire logic        instr_done,
	output logic             call_req,
	output logic [15:0]      call_vector,
	output logic             call_level,
	// Interrupt line.
	output logic             irq
);

	// ********************************************************************
	// State and helper signals.
	// ********************************************************************
	tlip_pkg::tlip_state_t s_q;
	tlip_pkg::tlip_state_t s_d;

	logic [11:0] src_req;
	logic [11:0] src_en;
	logic [11:0] active_req;
	logic        allow;
	logic        taken;
	logic        wr;
	logic [31:0] wm;
	logic [31:0] wd;
	logic [16:0] pend_clr;
	logic [16:0] ack_flags;

	tlip_pick_if #(.N(tlip_pkg::SOURCES)) pk ();

	tlip_pick #(
		.N (tlip_pkg::SOURCES)
	) u_pick (
		.pk (pk.picker)
	);

	// ********************************************************************
	// Request collection.
	// ********************************************************************
	// A source with several flags raises one request.
	for (genvar g = 0; g < tlip_pkg::SOURCES; g++) begin : g_src
		assign src_req[g] = |(s_q.pend & tlip_pkg::SRC_FLAGS[g]);
	end

	assign src_en     = {s_q.ext_en, s_q.en[tlip_pkg::SRC_EN_BITS-1:0]};
	// Nothing is recognised while the global enable is clear.
	assign active_req = src_req & src_en & {tlip_pkg::SOURCES{s_q.en[tlip_pkg::BIT_GLOBAL_EN]}};
	assign pk.req     = active_req;
	// Each source selects its level by its own bit.
	assign pk.hi      = s_q.prio;

	// High may enter over low; nothing enters over high or an equal level.
	assign allow     = pk.valid && !s_q.hold && !s_q.act_hi && (pk.lvl || !s_q.act_lo);
	assign taken     = call_ack && s_q.req;
	assign ack_flags = tlip_pkg::SRC_FLAGS[s_q.idx];

	// ********************************************************************
	// Next state.
	// ********************************************************************
	always_comb begin
		s_d      = s_q;
		wm       = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};
		wd       = wb_dat_w & wm;
		wr       = wb_cyc && wb_stb && wb_we && s_q.wb_ack;
		pend_clr = '0;

		// Bus answer one cycle after the strobe; writes land on the acknowledged edge.
		s_d.wb_ack = wb_cyc && wb_stb && !s_q.wb_ack;
		s_d.wb_dat = 32'h0000_0000;
		if (wb_cyc && wb_stb && !s_q.wb_ack && !wb_we) begin
			case (wb_adr)
				tlip_pkg::OFS_ENABLE:  s_d.wb_dat = {24'h00_0000, s_q.en};
				tlip_pkg::OFS_EXT_EN:  s_d.wb_dat = {26'h000_0000, s_q.ext_en};
				tlip_pkg::OFS_PRIO:    s_d.wb_dat = {20'h0_0000, s_q.prio};
				tlip_pkg::OFS_PEND:    s_d.wb_dat = {15'h0000, s_q.pend};
				tlip_pkg::OFS_IRQMASK: s_d.wb_dat = {15'h0000, s_q.mask};
				tlip_pkg::OFS_STATUS:  s_d.wb_dat = {23'h00_0000, s_q.act_hi, s_q.act_lo,
					s_q.hold, s_q.req, s_q.lvl, s_q.idx};
				default:               s_d.wb_dat = 32'h0000_0000;
			endcase
		end

		if (wr) begin
			case (wb_adr)
				// Six enables, spare flag and global enable, reset to zero.
				tlip_pkg::OFS_ENABLE:  s_d.en = (s_q.en & ~wm[7:0]) | wd[7:0];
				tlip_pkg::OFS_EXT_EN:  s_d.ext_en = (s_q.ext_en & ~wm[5:0]) | wd[5:0];
				// One selects the high level, zero the low level.
				tlip_pkg::OFS_PRIO:    s_d.prio = (s_q.prio & ~wm[11:0]) | wd[11:0];
				tlip_pkg::OFS_PEND:    pend_clr = wd[16:0];
				tlip_pkg::OFS_IRQMASK: s_d.mask = (s_q.mask & ~wm[16:0]) | wd[16:0];
				default:               s_d.en = s_q.en;
			endcase
		end

		// Pins and timers 0 and 1 lose their flag on vectoring.
		if (taken && tlip_pkg::HW_CLR_SRC[s_q.idx]) begin
			pend_clr = pend_clr | ack_flags;
		end
		// Events set flags whatever the enables, and win over a clear.
		s_d.pend = (s_q.pend & ~pend_clr) | flag_set;
		s_d.irq  = |(s_d.pend & s_d.mask);

		// Level tracking from the call acknowledge and the return notice.
		if (taken) begin
			if (s_q.lvl) begin
				s_d.act_hi = 1'b1;
			end else begin
				s_d.act_lo = 1'b1;
			end
		end
		if (ret_done) begin
			if (s_q.act_hi) begin
				s_d.act_hi = 1'b0;
			end else begin
				s_d.act_lo = 1'b0;
			end
			s_d.hold = 1'b1;
		end else if (s_q.hold && instr_done) begin
			// One instruction must complete after the return.
			s_d.hold = 1'b0;
		end

		// Arbitration runs every clock; a request is seen one clock later.
		if (taken || ret_done) begin
			s_d.req = 1'b0;
		end else begin
			s_d.req = allow;
		end
		if (allow) begin
			// Vectors start at 0x0003 and step by eight bytes.
			s_d.idx    = pk.idx;
			s_d.lvl    = pk.lvl;
			s_d.vector = tlip_pkg::VEC_FIRST + {9'h000, pk.idx, 3'h0};
		end
	end

	// ********************************************************************
	// State register.
	// ********************************************************************
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			// Reset leaves the vector at zero and every source at low level.
			s_q <= tlip_pkg::STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign wb_ack      = s_q.wb_ack;
	assign wb_dat_r    = s_q.wb_dat;
	assign call_req    = s_q.req;
	assign call_vector = s_q.vector;
	assign call_level  = s_q.lvl;
	assign irq         = s_q.irq;

	// ********************************************************************
	// Checks.
	// ********************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	property p_prio_reset;
		disable iff (1'b0) $fell(sys_rst) |-> s_q.prio == tlip_pkg::PRIO_RST && s_q.en == tlip_pkg::EN_RST;
	endproperty
	a_prio_reset: assert property (p_prio_reset) else $error("levels or enables not clear after reset");

	property p_hi_no_preempt;
		s_q.act_hi |-> !call_req;
	endproperty
	a_hi_no_preempt: assert property (p_hi_no_preempt) else $error("request raised over a high routine");

	property p_level_order;
		call_req && !call_level |-> $past(pk.req & pk.hi) == 12'h000;
	endproperty
	a_level_order: assert property (p_level_order) else $error("low request chosen over a high one");

	property p_detect_one;
		allow && !call_ack && !ret_done |=> call_req && call_level == $past(pk.lvl);
	endproperty
	a_detect_one: assert property (p_detect_one) else $error("request not presented one clock after detection");

	property p_vector_map;
		call_req |-> call_vector == tlip_pkg::VEC_FIRST + {9'h000, s_q.idx, 3'h0};
	endproperty
	a_vector_map: assert property (p_vector_map) else $error("vector does not match the selected source");

	property p_hw_clear;
		taken && tlip_pkg::HW_CLR_SRC[s_q.idx] && !(|(flag_set & ack_flags)) && !wr
			|=> (s_q.pend & $past(ack_flags)) == 17'h00000;
	endproperty
	a_hw_clear: assert property (p_hw_clear) else $error("pin or timer flag kept after vectoring");

	property p_global_gate;
		!s_q.en[tlip_pkg::BIT_GLOBAL_EN] ##1 !s_q.en[tlip_pkg::BIT_GLOBAL_EN] |-> !call_req;
	endproperty
	a_global_gate: assert property (p_global_gate) else $error("request with global enable clear");

	property p_flag_set;
		|flag_set |=> (s_q.pend & $past(flag_set)) == $past(flag_set);
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("set event lost");

	property p_ret_wait;
		ret_done |=> s_q.hold && !call_req ##1 !call_req;
	endproperty
	a_ret_wait: assert property (p_ret_wait) else $error("request within the instruction after return");

	property p_hold_blocks;
		s_q.hold |-> !call_req;
	endproperty
	a_hold_blocks: assert property (p_hold_blocks) else $error("request while waiting after return");

	property p_ack_track;
		taken && call_level && !ret_done |=> s_q.act_hi;
	endproperty
	a_ack_track: assert property (p_ack_track) else $error("high level not marked active on call");

	property p_irq_line;
		##1 irq == $past(|(s_d.pend & s_d.mask));
	endproperty
	a_irq_line: assert property (p_irq_line) else $error("interrupt line does not follow masked flags");

endmodule

// ===== verification/tlip_core_model.sv
`timescale 1ns/1ps
// ****
// Core that calls, services and returns.
// ****
module tlip_core_model (
	// Clock and reset.
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	// Pace set by the bench.
	input  wire logic       stall,
	input  wire logic [3:0] ack_dly,
	input  wire logic [7:0] svc_len,
	// Request side.
	input  wire logic       call_req,
	output logic            call_ack,
	output logic            ret_done,
	output logic            instr_done
);
	int wait_n;
	int svc_n;
	int depth;
	int ins_n;

	initial begin
		call_ack = 1'b0;
		ret_done = 1'b0;
		instr_done = 1'b0;
	end

	always @(posedge mclk) begin
		call_ack <= 1'b0;
		ret_done <= 1'b0;
		instr_done <= 1'b0;
		if (sys_rst) begin
			wait_n = 0;
			svc_n = 0;
			depth = 0;
			ins_n = 0;
		end else begin
			if (call_req && !stall && !call_ack) begin
				if (wait_n >= ack_dly) begin
					call_ack <= 1'b1;
					wait_n = 0;
					depth++;
					svc_n = svc_len;
				end else begin
					wait_n++;
				end
			end else begin
				wait_n = 0;
			end
			if (ins_n > 0) begin
				ins_n--;
				instr_done <= (ins_n == 0);
			end else if (depth > 0 && !call_ack) begin
				if (svc_n > 0) begin
					svc_n--;
				end else begin
					ret_done <= 1'b1;
					depth--;
					svc_n = svc_len;
					ins_n = tlip_pkg::DIV_CYC;
				end
			end
		end
	end
endmodule

// ===== verification/tlip_top_tb.sv
`timescale 1ns/1ps
module tlip_top_tb;
	logic        mclk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, stall = 0, prv = 0;
	logic        call_ack, ret_done, instr_done, call_req, call_level, irq, wb_ack;
	logic [7:0]  adr = '0, svc = 8'h06;
	logic [3:0]  sel = '0, ackd = '0;
	logic [31:0] dw = '0, wb_dat_r, r;
	logic [16:0] fs = '0;
	logic [15:0] call_vector;
	logic [16:0] q[$];
	int          err_count = 0, compares = 0, cyc_n = 0, gap = 0, rgap = 0;
	int          fl[12] = '{0, 1, 2, 3, 4, 6, 8, 9, 10, 11, 15, 16};

	tlip_top u_tlip_top (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we),
		.wb_adr(adr), .wb_sel(sel), .wb_dat_w(dw), .wb_ack(wb_ack), .wb_dat_r(wb_dat_r),
		.flag_set(fs), .call_ack(call_ack), .ret_done(ret_done), .instr_done(instr_done),
		.call_req(call_req), .call_vector(call_vector), .call_level(call_level), .irq(irq));
	tlip_core_model u_tlip_core_model (.mclk(mclk), .sys_rst(sys_rst), .stall(stall), .ack_dly(ackd),
		.svc_len(svc), .call_req(call_req), .call_ack(call_ack), .ret_done(ret_done),
		.instr_done(instr_done));

	always #50 mclk = ~mclk;

	// ****
	// Helpers.
	// ****
	always @(negedge mclk) begin
		if (call_ack) q.push_back({call_level, call_vector});
		gap = instr_done ? 0 : gap + 1;
		if (call_req && !prv) rgap = gap;
		prv = call_req;
	end

	always @(posedge mclk) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			err_count++;
			summarize;
		end
	end

	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= 4'hf; dw <= d;
		do @(posedge mclk); while (wb_ack !== 1'b1);
		r = wb_dat_r;
		cyc <= 0; stb <= 0;
	endtask

	task rst;
		@(posedge mclk);
		sys_rst <= 1;
		repeat (3) @(posedge mclk);
		sys_rst <= 0;
		q.delete();
	endtask

	task pulse(input logic [16:0] f);
		@(posedge mclk);
		fs <= f;
		@(posedge mclk);
		fs <= '0;
	endtask

	task waitq(input int n);
		int k;
		k = 0;
		while (q.size() < n && k < 400) begin @(negedge mclk); k++; end
		chk(q.size() >= n, 1);
	endtask

	task endt(input string s);
		$display("test %s finished", s);
	endtask

	task summarize;
		$display("comparisons %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ****
	// Sequence.
	// ****
	initial begin
		int w, n;
		logic [11:0] p, s;
		logic [16:0] f;
		void'($urandom(32'hc1b514c2));
		rst;
		wb(0, 8'ha8, 0); chk(r, 0);
		wb(0, 8'hb0, 0); chk(r, 0);
		wb(1, 8'hc0, '1); wb(0, 8'hc0, 0); chk(r, 0);
		endt("reset");
		repeat (8) begin
			rst;
			stall <= 1;
			p = 12'($urandom);
			s = 12'($urandom);
			s[$urandom % 12] = 1'b1;
			f = '0;
			w = -1;
			for (int i = 0; i < 12; i++) begin
				if (s[i]) f[fl[i]] = 1'b1;
				if (s[i] && (w < 0 || (p[i] && !p[w]))) w = i;
			end
			wb(1, 8'ha8, 32'h3f); wb(1, 8'hac, 32'h3f); wb(1, 8'hb0, {20'h0, p}); wb(1, 8'hb8, 32'h1ffff);
			pulse(f);
			repeat (3) @(negedge mclk);
			chk(call_req, 0);
			chk(irq, 1);
			wb(0, 8'hb4, 0); chk(r, {15'h0, f});
			wb(1, 8'ha8, 32'hbf);
			repeat (3) @(negedge mclk);
			chk(call_req, 1);
			chk(call_vector, 16'h0003 + 16'(8 * w));
			chk(call_level, p[w]);
			wb(1, 8'hb8, 0); @(negedge mclk); chk(irq, 0);
			wb(1, 8'hb4, 32'h1ffff); wb(0, 8'hb4, 0); chk(r, 0);
			wb(1, 8'hb8, 32'h1ffff); @(negedge mclk); chk(irq, 0);
		end
		endt("arbitration");
		rst;
		stall <= 0;
		ackd <= 4'(tlip_pkg::CALL_CYC - 1);
		wb(1, 8'ha8, 32'h92);
		pulse(17'h2);
		n = 0;
		while (call_req !== 1'b1 && n < 20) begin @(negedge mclk); n++; end
		chk(n, 2);
		waitq(1); chk(q[0], 17'h0000b);
		wb(0, 8'hb4, 0); chk(r[1], 0);
		pulse(17'h10);
		waitq(3); chk(q[1], 17'h00023); chk(q[2], 17'h00023);
		wb(0, 8'hb4, 0); chk(r[4], 1);
		endt("latency");
		rst;
		svc <= 8'd20;
		wb(1, 8'hb0, 32'h5); wb(1, 8'hac, 32'h1); wb(1, 8'ha8, 32'h85);
		pulse(17'h100); waitq(1);
		pulse(17'h1); waitq(2);
		pulse(17'h4); waitq(3);
		chk(q[0], 17'h00033); chk(q[1], 17'h10003); chk(q[2], 17'h10013);
		chk(rgap, 2);
		endt("nesting");
		summarize;
	end
endmodule
